// ==== dbh_defines.svh ====
// Purpose: Constants for the debug pin acknowledge handshake
// Assumes: Counts are in serial clock ticks unless noted
// Notes: Included by the package and the design file
`ifndef DBH_DEFINES_SVH
`define DBH_DEFINES_SVH

// ==========================================================
// Serial timing, in serial clock ticks
`define DBH_ACK_LOW_TICKS 8'h10
`define DBH_ACK_MIN_DELAY 8'h20
`define DBH_SYNC_DELAY 8'h10
`define DBH_SYNC_LOW_TICKS 8'h80
`define DBH_SYNC_REQ_TICKS 8'h80
`define DBH_SPEEDUP_TICKS 8'h01

// ==========================================================
// Serial clock source and data path
`define DBH_OSC_DIV 4'h4
`define DBH_DATA_W 16
`define DBH_FIFO_DEPTH 16

`endif

// ==== dbh_pkg.sv ====
// Purpose: Types for the debug pin acknowledge handshake
// Assumes: dbh_defines.svh gives the widths
// Notes: State is one packed struct
`include "dbh_defines.svh"

package dbh_pkg;

  // ==========================================================
  // Handshake sequencer states, Gray coded along the path
  typedef enum logic [2:0] {
    DBH_IDLE = 3'h0,
    DBH_WAIT = 3'h1,
    DBH_ACK_LO = 3'h3,
    DBH_ACK_HI = 3'h2,
    DBH_SYNC_WH = 3'h6,
    DBH_SYNC_DL = 3'h7,
    DBH_SYNC_LO = 3'h5,
    DBH_SYNC_HI = 3'h4
  } dbh_state_type;

  // ==========================================================
  // Decoded command, given with the command end pulse
  typedef struct packed {
    logic is_read;
    logic needs_cpu;
    logic ack_on;
    logic ack_off;
  } dbh_cmd_type;

  // ==========================================================
  // Whole state of the handshake block
  typedef struct packed {
    dbh_state_type st;
    logic [7:0] cnt;
    logic [7:0] low_cnt;
    logic [3:0] div;
    logic pin_prev;
    logic drv_en;
    logic drv_out;
    logic ack_en;
    logic pending;
    logic is_read;
    logic executed;
    logic soft_rst;
    logic cmd_ready;
  } dbh_regs_type;

endpackage

// ==== dbh_ack_handshake.sv ====
// Purpose: Acknowledge pulse, abort and timing reference on the debug pin
// Assumes: debug_pin_in synchronous to clk; decoder flags command end
// Notes: Read data passes a 16 word FIFO toward the serial side
//
// Functional notes
// - Acknowledge is 16 ticks low, then a high speedup, then release.
// - Acknowledge only after the issued command has really executed.
// - Acknowledge starts no earlier than 32 ticks after command end.
// - Wait or stop before execution drops the command without acknowledge.
// - Byte read: opcode, address, bus cycle, acknowledge, word retrieval.
// - Target opens acknowledge with its own falling edge; host stays off.
// - No nested acknowledges; pending command must be aborted first.
// - Command needing the CPU arriving during wait or stop is discarded, not acknowledged.
// - Pending acknowledge never times out.
// - Long low runs the timing reference and aborts the pending command.
// - Short low aborts on its falling edge, no timing reference.
// - Next falling edge after an abort starts a new command.
// - Pin driven high only during speedup pulses.
// - Handshake turned on and off by commands, off after reset.
// - Bits are 16 ticks each, MSB first, started by host edges.
// - Reference: wait high, 16 ticks, 128 ticks low, one tick high.
// - Reads acknowledge when data ready, writes when bus cycle done.
`timescale 1ns/1ps
`include "dbh_defines.svh"

// ==========================================================
// FIFO with valid and ready on both sides
module dbh_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_ff;
  logic [AW:0] rd_ptr_ff;
  logic push;
  logic pop;

  assign in_ready = (wr_ptr_ff[AW] == rd_ptr_ff[AW]) ||
                    (wr_ptr_ff[AW-1:0] != rd_ptr_ff[AW-1:0]);
  assign out_valid = wr_ptr_ff != rd_ptr_ff;
  assign out_data = mem[rd_ptr_ff[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_ff[AW-1:0]] <= in_data;
    end
  end
endmodule

// ==========================================================
// Acknowledge handshake top
module dbh_ack_handshake (
  input wire logic clk,
  input wire logic reset,
  input wire logic serial_clock_select,
  input wire logic debug_pin_in,
  output logic debug_pin_out,
  output logic debug_pin_oe,
  input wire logic cmd_end,
  input wire dbh_pkg::dbh_cmd_type cmd_kind,
  input wire logic exec_done,
  input wire logic cpu_wait_stop,
  input wire logic bus_rdata_valid,
  output logic bus_rdata_ready,
  input wire logic [`DBH_DATA_W-1:0] bus_rdata,
  output logic rd_word_valid,
  input wire logic rd_word_ready,
  output logic [`DBH_DATA_W-1:0] rd_word,
  output logic soft_reset,
  output logic cmd_ready,
  output logic ack_enabled
);
  import dbh_pkg::*;

  dbh_regs_type s_ff;
  dbh_regs_type nxt_s;
  logic tick;
  logic host_low;
  logic fall;
  logic data_ready;
  logic accept;

  // ==========================================================
  // Read data buffer
  dbh_fifo #(
    .WIDTH(`DBH_DATA_W),
    .DEPTH(`DBH_FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .reset(reset),
    .in_valid(bus_rdata_valid),
    .in_ready(bus_rdata_ready),
    .in_data(bus_rdata),
    .out_valid(rd_word_valid),
    .out_ready(rd_word_ready),
    .out_data(rd_word)
  );

  // ==========================================================
  // Next state
  always_comb begin
    nxt_s = s_ff;
    nxt_s.soft_rst = 1'b0;
    // Serial tick: bus clock or divided oscillator
    if (serial_clock_select) begin
      tick = 1'b1;
      nxt_s.div = 4'h0;
    end else begin
      tick = s_ff.div == (`DBH_OSC_DIV - 4'h1);
      nxt_s.div = tick ? 4'h0 : s_ff.div + 4'h1;
    end
    host_low = !debug_pin_in && !s_ff.drv_en;
    fall = s_ff.pin_prev && host_low;
    nxt_s.pin_prev = debug_pin_in;
    data_ready = !s_ff.is_read || rd_word_valid;
    // Commands needing the CPU are dropped during wait or stop
    accept = cmd_end && !(cmd_kind.needs_cpu && cpu_wait_stop);

    // Host low time, saturating at the reference request length
    if (host_low) begin
      if (tick && s_ff.low_cnt != `DBH_SYNC_REQ_TICKS) begin
        nxt_s.low_cnt = s_ff.low_cnt + 8'h01;
      end
    end else begin
      nxt_s.low_cnt = 8'h00;
    end

    // Handshake enable and disable commands
    if (accept && cmd_kind.ack_on) begin
      nxt_s.ack_en = 1'b1;
    end else if (accept && cmd_kind.ack_off) begin
      nxt_s.ack_en = 1'b0;
    end

    case (s_ff.st)
      DBH_IDLE: begin
        // The enable command acknowledges itself
        if (accept && nxt_s.ack_en) begin
          nxt_s.st = DBH_WAIT;
          nxt_s.pending = 1'b1;
          nxt_s.cmd_ready = 1'b0;
          nxt_s.is_read = cmd_kind.is_read;
          nxt_s.executed = !cmd_kind.needs_cpu;
          nxt_s.cnt = 8'h00;
        end
      end
      DBH_WAIT: begin
        if (tick && s_ff.cnt != `DBH_ACK_MIN_DELAY) begin
          nxt_s.cnt = s_ff.cnt + 8'h01;
        end
        if (exec_done) begin
          nxt_s.executed = 1'b1;
        end
        if (fall) begin
          // Short abort: falling edge alone drops the command
          nxt_s.st = DBH_IDLE;
          nxt_s.pending = 1'b0;
          nxt_s.cmd_ready = 1'b1;
          nxt_s.soft_rst = 1'b1;
        end else if (cpu_wait_stop && !s_ff.executed) begin
          nxt_s.st = DBH_IDLE;
          nxt_s.pending = 1'b0;
          nxt_s.cmd_ready = 1'b1;
        end else if (s_ff.cnt == `DBH_ACK_MIN_DELAY && s_ff.executed &&
                     tick && data_ready) begin
          // Starts on a tick so the low phase is whole ticks
          nxt_s.st = DBH_ACK_LO;
          nxt_s.cnt = 8'h00;
          nxt_s.drv_en = 1'b1;
          nxt_s.drv_out = 1'b0;
        end
      end
      DBH_ACK_LO: begin
        if (tick) begin
          nxt_s.cnt = s_ff.cnt + 8'h01;
          if (s_ff.cnt == `DBH_ACK_LOW_TICKS - 8'h01) begin
            nxt_s.st = DBH_ACK_HI;
            nxt_s.drv_out = 1'b1;
            nxt_s.cnt = 8'h00;
          end
        end
      end
      DBH_ACK_HI: begin
        if (tick) begin
          nxt_s.cnt = s_ff.cnt + 8'h01;
          if (s_ff.cnt == `DBH_SPEEDUP_TICKS - 8'h01) begin
            nxt_s.st = DBH_IDLE;
            nxt_s.drv_en = 1'b0;
            nxt_s.drv_out = 1'b0;
            nxt_s.pending = 1'b0;
            nxt_s.cmd_ready = 1'b1;
          end
        end
      end
      DBH_SYNC_WH: begin
        if (debug_pin_in && tick) begin
          nxt_s.st = DBH_SYNC_DL;
          nxt_s.cnt = 8'h00;
        end
      end
      DBH_SYNC_DL: begin
        if (tick) begin
          nxt_s.cnt = s_ff.cnt + 8'h01;
          if (s_ff.cnt == `DBH_SYNC_DELAY - 8'h01) begin
            nxt_s.st = DBH_SYNC_LO;
            nxt_s.cnt = 8'h00;
            nxt_s.drv_en = 1'b1;
            nxt_s.drv_out = 1'b0;
          end
        end
      end
      DBH_SYNC_LO: begin
        if (tick) begin
          nxt_s.cnt = s_ff.cnt + 8'h01;
          if (s_ff.cnt == `DBH_SYNC_LOW_TICKS - 8'h01) begin
            nxt_s.st = DBH_SYNC_HI;
            nxt_s.cnt = 8'h00;
            nxt_s.drv_out = 1'b1;
          end
        end
      end
      DBH_SYNC_HI: begin
        if (tick) begin
          nxt_s.cnt = s_ff.cnt + 8'h01;
          if (s_ff.cnt == `DBH_SPEEDUP_TICKS - 8'h01) begin
            nxt_s.st = DBH_IDLE;
            nxt_s.drv_en = 1'b0;
            nxt_s.drv_out = 1'b0;
            nxt_s.cmd_ready = 1'b1;
          end
        end
      end
      default: begin
        nxt_s.st = DBH_IDLE;
        nxt_s.drv_en = 1'b0;
        nxt_s.drv_out = 1'b0;
      end
    endcase

    // Long host low: timing reference, pending command aborted
    if (s_ff.st != DBH_SYNC_WH && s_ff.st != DBH_SYNC_DL &&
        s_ff.st != DBH_SYNC_LO && s_ff.st != DBH_SYNC_HI &&
        host_low && nxt_s.low_cnt == `DBH_SYNC_REQ_TICKS) begin
      nxt_s.st = DBH_SYNC_WH;
      nxt_s.pending = 1'b0;
      nxt_s.cmd_ready = 1'b0;
      nxt_s.drv_en = 1'b0;
      nxt_s.drv_out = 1'b0;
      nxt_s.soft_rst = 1'b1;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      s_ff <= '{st: DBH_IDLE, cnt: 8'h00, low_cnt: 8'h00, div: 4'h0,
                pin_prev: 1'b1, drv_en: 1'b0, drv_out: 1'b0,
                ack_en: 1'b0, pending: 1'b0, is_read: 1'b0,
                executed: 1'b0, soft_rst: 1'b0, cmd_ready: 1'b1};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign debug_pin_out = s_ff.drv_out;
  assign debug_pin_oe = s_ff.drv_en;
  assign soft_reset = s_ff.soft_rst;
  assign cmd_ready = s_ff.cmd_ready;
  assign ack_enabled = s_ff.ack_en;
endmodule

// ==== dbh_ack_handshake_properties.sv ====
// Purpose: Port assertions for the acknowledge handshake
// Assumes: Pulse widths checked only with a tick every clk
// Notes: Bound to every dbh_ack_handshake
`timescale 1ns/1ps

module dbh_ack_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic serial_clock_select,
  input wire logic debug_pin_in,
  input wire logic debug_pin_out,
  input wire logic debug_pin_oe,
  input wire logic cmd_end,
  input wire dbh_pkg::dbh_cmd_type cmd_kind,
  input wire logic cpu_wait_stop,
  input wire logic soft_reset,
  input wire logic cmd_ready,
  input wire logic ack_enabled
);
  import dbh_pkg::*;
  logic [7:0] since_ff;

  // ==========================================================
  // Cycles since the last accepted command end
  always_ff @(posedge clk)
    if (reset) since_ff <= 8'hff;
    else if (cmd_end && cmd_ready) since_ff <= 8'h00;
    else if (since_ff != 8'hff) since_ff <= since_ff + 8'h01;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // ==========================================================
  // Reset state, pin drive shape, acknowledge gap, abort and command take checks
  sequence s_low8;
    (debug_pin_oe && !debug_pin_out) [*8];
  endsequence
  sequence s_take;
    cmd_end && cmd_ready;
  endsequence
  property p_rst;
    $fell(reset) |-> !debug_pin_oe && cmd_ready && !ack_enabled;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_fall;
    $rose(debug_pin_oe) |-> !debug_pin_out;
  endproperty
  a_fall: assert property (p_fall) else $error("drive not low");
  property p_low;
    $rose(debug_pin_oe) && serial_clock_select |-> s_low8 ##1 s_low8;
  endproperty
  a_low: assert property (p_low) else $error("low too short");
  property p_spd;
    $fell(debug_pin_oe) && serial_clock_select && !$past(reset)
      |-> $past(debug_pin_out) && !$past(debug_pin_out, 2);
  endproperty
  a_spd: assert property (p_spd) else $error("bad speedup");
  property p_gap;
    $rose(debug_pin_oe) |-> since_ff >= 8'h20;
  endproperty
  a_gap: assert property (p_gap) else $error("ack too early");
  property p_abort;
    $fell(debug_pin_in) && !debug_pin_oe && !cmd_ready
      |=> soft_reset && cmd_ready;
  endproperty
  a_abort: assert property (p_abort) else $error("no abort");
  property p_pend;
    s_take ##0 (ack_enabled || cmd_kind.ack_on) && !cmd_kind.ack_off
      && !(cmd_kind.needs_cpu && cpu_wait_stop) |=> !cmd_ready;
  endproperty
  a_pend: assert property (p_pend) else $error("not pending");
  property p_disc;
    s_take ##0 cmd_kind.needs_cpu && cpu_wait_stop |=> cmd_ready;
  endproperty
  a_disc: assert property (p_disc) else $error("not discarded");
endmodule

bind dbh_ack_handshake dbh_ack_checker u_chk (.clk, .reset,
  .serial_clock_select, .debug_pin_in, .debug_pin_out, .debug_pin_oe,
  .cmd_end, .cmd_kind, .cpu_wait_stop, .soft_reset, .cmd_ready,
  .ack_enabled);

// ==== dbh_probe_model.sv ====
// Purpose: Host probe that pulls the debug pin for aborts
// Assumes: Called just after a clock edge
// Notes: Never drives while the target acknowledges
`timescale 1ns/1ps

module dbh_probe (
  input wire logic clk,
  input wire logic serial_clock_select,
  output logic probe_oe,
  output logic probe_out
);
  initial begin
    probe_oe = 1'b0;
    probe_out = 1'b0;
  end

  // ==========================================================
  // Low for some ticks, one tick speedup, then release
  task automatic abort(input int ticks);
    int f;
    f = serial_clock_select ? 1 : 4;
    probe_out = 1'b0;
    probe_oe = 1'b1;
    repeat (ticks * f) @(posedge clk);
    #2;
    probe_out = 1'b1;
    repeat (f) @(posedge clk);
    #2;
    probe_oe = 1'b0;
  endtask
endmodule

// ==== tb.sv ====
// Purpose: Self-checking bench for the acknowledge handshake
// Assumes: Pin pulled high when nobody drives it low
// Notes: f is the serial tick length in clk cycles
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((e) !== (s)) begin \
  fail_count++; $display("wrong value %s exp %0h got %0h", n, e, s); \
  end end

module tb;
  import dbh_pkg::*;
  logic clk, reset, sel, ce, ex, ws, bv, br, rv, rr, d_out, d_oe;
  logic p_oe, p_out, sr, cr, ae;
  dbh_cmd_type k;
  logic [15:0] bd, rw, w;
  wire logic pin = !((d_oe && !d_out) || (p_oe && !p_out));
  int fail_count, comparisons, f, t, lo, hi, nsr;
  logic [15:0] q[$];

  dbh_ack_handshake dut (.clk, .reset, .serial_clock_select(sel),
    .debug_pin_in(pin), .debug_pin_out(d_out), .debug_pin_oe(d_oe),
    .cmd_end(ce), .cmd_kind(k), .exec_done(ex), .cpu_wait_stop(ws),
    .bus_rdata_valid(bv), .bus_rdata_ready(br), .bus_rdata(bd),
    .rd_word_valid(rv), .rd_word_ready(rr), .rd_word(rw),
    .soft_reset(sr), .cmd_ready(cr), .ack_enabled(ae));
  dbh_probe probe (.clk, .serial_clock_select(sel), .probe_oe(p_oe),
    .probe_out(p_out));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) if (sr === 1'b1) nsr++;

  task tick;
    @(posedge clk);
    #2;
  endtask
  task close_out;
    $display("mismatches %0d of %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task till(input logic v);
    t = 0;
    while (d_oe !== v && t < 4000) begin
      tick;
      t++;
    end
    if (t >= 4000) begin
      fail_count++;
      close_out;
    end
  endtask
  task meas;
    lo = 0;
    hi = 0;
    while (d_oe === 1'b1 && lo + hi < 300) begin
      if (d_out) hi++;
      else lo++;
      tick;
    end
  endtask
  task cmd(input dbh_cmd_type c);
    k = c;
    ce = 1'b1;
    tick;
    ce = 1'b0;
  endtask
  task ack(input int d);
    repeat (d) tick;
    ex = 1'b1;
    tick;
    ex = 1'b0;
    till(1'b1);
    `CHK("delay", 1'b1, d + t + 1 >= 32 * f)
    meas;
    `CHK("low", 16 * f, lo)
    `CHK("high", f, hi)
    `CHK("ready", 1'b1, cr)
  endtask

  initial begin
    void'($urandom(85592));
    {ce, ex, ws, bv, rr, sel, k, bd} = '0;
    reset = 1'b1;
    repeat (3) tick;
    reset = 1'b0;
    `CHK("rst", 3'b010, {d_oe, cr, ae})
    for (int s = 1; s >= 0; s--) begin
      sel = s[0];
      f = s ? 1 : 4;
      cmd(4'h0);
      tick;
      `CHK("idle", 1'b1, cr)
      cmd(4'h2);
      ack(0);
      cmd(4'h4);
      ack($urandom_range(80, 5));
      cmd(4'h1);
      tick;
      `CHK("off", 2'b01, {ae, cr})
    end
    sel = 1'b1;
    f = 1;
    cmd(4'h2);
    ack(0);
    // ==========================================================
    // Fill the read buffer, acknowledge, drain with stalls
    for (int i = 0; i < 16; i++) begin
      bv = 1'b1;
      bd = 16'($urandom);
      q.push_back(bd);
      tick;
    end
    bv = 1'b0;
    `CHK("full", 1'b0, br)
    cmd(4'hc);
    ack(3);
    t = 0;
    while (q.size() > 0 && t < 300) begin
      rr = 1'($urandom);
      if (rr && rv) begin
        w = q.pop_front();
        `CHK("word", w, rw)
      end
      tick;
      t++;
    end
    rr = 1'b0;
    `CHK("empty", 1'b0, rv)
    // ==========================================================
    // Read held back until its word arrives
    cmd(4'hc);
    ex = 1'b1;
    tick;
    ex = 1'b0;
    repeat (50) tick;
    `CHK("rwait", 2'b00, {d_oe, cr})
    bv = 1'b1;
    bd = 16'($urandom);
    q.push_back(bd);
    tick;
    bv = 1'b0;
    till(1'b1);
    meas;
    `CHK("rlow", 16, lo)
    rr = 1'b1;
    w = q.pop_front();
    `CHK("rword", w, rw)
    tick;
    rr = 1'b0;
    // ==========================================================
    // Stuck command, long abort and reference pulse
    cmd(4'h4);
    repeat (300) tick;
    `CHK("hold", 2'b00, {d_oe, cr})
    nsr = 0;
    probe.abort(130);
    till(1'b1);
    meas;
    `CHK("sync", 2'b11, {nsr > 0, t >= 14})
    `CHK("slow", 128, lo)
    `CHK("shigh", 1, hi)
    `CHK("sfree", 1'b1, cr)
    cmd(4'h4);
    tick;
    nsr = 0;
    probe.abort(4);
    repeat (40) tick;
    `CHK("short", 3'b110, {nsr == 1, cr, d_oe})
    cmd(4'h4);
    ack(2);
    // ==========================================================
    // Wait or stop discards and drops commands
    ws = 1'b1;
    cmd(4'h4);
    tick;
    `CHK("disc", 1'b1, cr)
    ws = 1'b0;
    cmd(4'h4);
    ws = 1'b1;
    repeat (2) tick;
    ws = 1'b0;
    repeat (60) tick;
    `CHK("drop", 2'b01, {d_oe, cr})
    close_out;
  end

  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    close_out;
  end
endmodule
